/* File: design/event_status.sv */
// Sticky event flags with write-one-to-clear, a mask and one level interrupt
`default_nettype none
module event_status #(
    parameter int N = 4
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [N-1:0] set,
    input wire logic clear_wr,
    input wire logic mask_wr,
    input wire logic [N-1:0] wdata,
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);
    // ==========================================
    // Parameter check
    if (N < 1 || N > 32) begin : g_bad_count
        $error("event_status count out of range");
    end
    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
        logic irq;
    } flags_type;
    flags_type st;
    flags_type next_st;
    // ==========================================
    // A new event wins over a clear in the same cycle
    always_comb begin
        next_st = st;
        if (clear_wr) begin
            next_st.status = st.status & ~wdata;
        end
        next_st.status = next_st.status | set;
        if (mask_wr) begin
            next_st.mask = wdata;
        end
        next_st.irq = |(next_st.status & next_st.mask);
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign status = st.status;
    assign mask = st.mask;
    assign irq = st.irq;
    // Event kept even when cleared in the same cycle
    set_wins_a: assert property (@(posedge clock) disable iff (!nrst)
        (set != '0) |=> ((status & $past(set)) == $past(set)))
        else $error("event lost against clear");
endmodule : event_status
`default_nettype wire

/* File: design/match_compare.sv */
// Equality detector that pulses once when a counter reaches its match value
`default_nettype none
module match_compare #(
    parameter int W = 24
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic enable,
    input wire logic [W-1:0] target,
    input wire logic [W-1:0] count,
    output logic hit
);
    // ==========================================
    // Parameter check
    if (W < 2 || W > 32) begin : g_bad_width
        $error("match_compare width out of range");
    end
    // State: equality seen last cycle, pulse out
    typedef struct packed {
        logic eq_prev;
        logic hit;
    } cmp_type;
    cmp_type st;
    cmp_type next_st;
    logic eq; // Equal and in use
    assign eq = enable && (target == count);
    // ==========================================
    // Pulse on the first cycle of equality
    always_comb begin
        next_st.eq_prev = eq;
        next_st.hit = eq && !st.eq_prev;
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign hit = st.hit;
    // One pulse per arrival at the match value
    match_pulse_a: assert property (@(posedge clock) disable iff (!nrst)
        (eq && !st.eq_prev) |=> hit ##1 !hit)
        else $error("match pulse missing or too long");
endmodule : match_compare
`default_nettype wire

/* File: design/timer_match_map.svh */
// Register offsets, field slices and reset values of the match and prescale registers
`ifndef TIMER_MATCH_MAP_SVH
`define TIMER_MATCH_MAP_SVH
// ==========================================
// Register offsets (byte addresses)
`define OFS_A_LOAD 8'h28
`define OFS_B_LOAD 8'h2c
`define OFS_A_MATCH 8'h30
`define OFS_B_MATCH 8'h34
`define OFS_A_PSC 8'h38
`define OFS_B_PSC 8'h3c
`define OFS_A_PSC_MATCH 8'h40
`define OFS_B_PSC_MATCH 8'h44
`define OFS_A_VIEW 8'h48
`define OFS_B_VIEW 8'h4c
`define OFS_STATUS 8'h50
`define OFS_MASK 8'h54
// ==========================================
// Field slices
`define HALF_HI 31:16
`define HALF_LO 15:0
`define PSC_FIELD 7:0
`define IRQ_FIELD 3:0
// ==========================================
// Reset and padding values
`define RST_HALF 16'hffff
`define ZERO_HALF 16'h0000
`define RST_PSC 8'h00
`define PAD_PSC 24'h000000
`define PAD_IRQ 28'h0000000
`define ZERO_WORD 32'h00000000
`define IRQ_COUNT 4
`endif

/* File: design/timer_match_pkg.sv */
// Types shared by the match and prescale register block
`default_nettype none
package timer_match_pkg;
    // Counting mode of one timer half
    typedef enum logic [2:0] {
        MODE_ONE_SHOT,
        MODE_PERIODIC,
        MODE_EDGE_TIME,
        MODE_EDGE_COUNT,
        MODE_PWM
    } mode_type;
    // State of the register block outside the flag and match submodules
    typedef struct packed {
        logic [15:0] tb_load;
        logic [15:0] a_match_hi;
        logic [15:0] a_match_lo;
        logic [15:0] b_match;
        logic [7:0] a_psc;
        logic [7:0] b_psc;
        logic [7:0] a_psc_match;
        logic [7:0] b_psc_match;
        logic [15:0] a_stamp;
        logic [15:0] b_stamp;
        logic [15:0] a_edges;
        logic [15:0] b_edges;
        logic [1:0] edge_done;
        logic [1:0] pwm;
        logic [31:0] rdata;
    } regs_type;
endpackage : timer_match_pkg
`default_nettype wire

/* File: design/timer_match_regs.sv */
// Match, prescale, interval load and counter view registers of a dual timer
// ==========================================
//
// Decided for this implementation: the address-and-strobe port.
`include "timer_match_map.svh"
`default_nettype none
module timer_match_regs
    import timer_match_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic WIDE,
    input wire logic RTC,
    input wire mode_type A_MODE,
    input wire mode_type B_MODE,
    input wire logic [15:0] A_LOAD,
    input wire logic [15:0] COUNT_A,
    input wire logic [15:0] COUNT_B,
    input wire logic [7:0] PSC_COUNT_A,
    input wire logic [7:0] PSC_COUNT_B,
    input wire logic EDGE_A,
    input wire logic EDGE_B,
    output logic [15:0] TB_LOAD_VALUE,
    output logic [7:0] A_PRESCALE,
    output logic [7:0] B_PRESCALE,
    output logic MATCH_A,
    output logic MATCH_B,
    output logic PWM_A,
    output logic PWM_B,
    output logic EDGE_DONE_A,
    output logic EDGE_DONE_B,
    output logic IRQ
);
    // ==========================================
    // Helpers
    // Write or read strobe at one offset
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction : hit
    // Edge counter step: bit 16 flags that the target was reached
    function automatic logic [16:0] edge_step(input logic en, input logic pulse,
                                              input logic [15:0] edges,
                                              input logic [15:0] target);
        logic [15:0] inc;
        inc = edges + 16'h0001;
        if (!en) begin
            edge_step = {1'b0, `ZERO_HALF};
        end else if (pulse && inc == target) begin
            edge_step = {1'b1, `ZERO_HALF};
        end else if (pulse) begin
            edge_step = {1'b0, inc};
        end else begin
            edge_step = {1'b0, edges};
        end
    endfunction : edge_step
    // ==========================================
    // State and decoded conditions
    regs_type st; // Registered state
    regs_type next_st; // Next state
    logic wide_rtc; // 32-bit real-time clock use
    logic a_used; // Timer A match in use, narrow
    logic b_used; // Timer B match in use
    logic a_edge_mode; // Timer A edge count mode
    logic b_edge_mode; // Timer B edge count mode
    logic a_view_edge; // Timer A view shows timestamp
    logic b_view_edge; // Timer B view shows timestamp
    logic [15:0] b_view; // Timer B counter view
    logic [31:0] a_cmp_target; // Timer A compare value
    logic [31:0] a_cmp_count; // Timer A counted value
    logic [16:0] a_step; // Timer A edge step
    logic [16:0] b_step; // Timer B edge step
    logic [3:0] events; // Event set vector
    logic [3:0] flags; // Sticky event flags
    logic [3:0] enables; // Event mask
    logic match_a_hit; // Timer A compare pulse
    logic match_b_hit; // Timer B compare pulse
    logic irq_level; // Interrupt level
    // Modes that use the match registers
    assign wide_rtc = WIDE && RTC;
    assign a_edge_mode = !WIDE && (A_MODE == MODE_EDGE_COUNT);
    assign b_edge_mode = !WIDE && (B_MODE == MODE_EDGE_COUNT);
    assign a_used = !WIDE && (A_MODE == MODE_PWM || a_edge_mode);
    assign b_used = !WIDE && (B_MODE == MODE_PWM || b_edge_mode);
    // Views show a timestamp in either edge mode
    assign a_view_edge = (A_MODE == MODE_EDGE_COUNT || A_MODE == MODE_EDGE_TIME);
    assign b_view_edge = (B_MODE == MODE_EDGE_COUNT || B_MODE == MODE_EDGE_TIME);
    // Timer B view, also the high half of the wide A view
    assign b_view = b_view_edge ? st.b_stamp : COUNT_B;
    // ==========================================
    // Compare operands for timer A
    always_comb begin
        if (wide_rtc) begin
            // High match against B count, low against A count
            a_cmp_target = {st.a_match_hi, st.a_match_lo};
            a_cmp_count = {COUNT_B, COUNT_A};
        end else begin
            // Prescale match above the 16-bit match
            a_cmp_target = {`RST_PSC, st.a_psc_match, st.a_match_lo};
            a_cmp_count = {`RST_PSC, PSC_COUNT_A, COUNT_A};
        end
    end
    // Timer A match detector
    match_compare #(
        .W(32)
    ) u_match_a (
        .clock(CLOCK),
        .nrst(NRST),
        .enable(wide_rtc || a_used),
        .target(a_cmp_target),
        .count(a_cmp_count),
        .hit(match_a_hit)
    );
    // Timer B match detector, 24 bits with prescale
    match_compare #(
        .W(24)
    ) u_match_b (
        .clock(CLOCK),
        .nrst(NRST),
        .enable(b_used),
        .target({st.b_psc_match, st.b_match}),
        .count({PSC_COUNT_B, COUNT_B}),
        .hit(match_b_hit)
    );
    // Edge counting steps
    assign a_step = edge_step(a_edge_mode, EDGE_A, st.a_edges,
                              A_LOAD - st.a_match_lo);
    assign b_step = edge_step(b_edge_mode, EDGE_B, st.b_edges,
                              st.tb_load - st.b_match);
    // Events: bit 0 match A, 1 match B, 2 edges A, 3 edges B
    assign events = {st.edge_done[1], st.edge_done[0], match_b_hit, match_a_hit};
    // ==========================================
    // Interrupt flags
    event_status #(
        .N(`IRQ_COUNT)
    ) u_status (
        .clock(CLOCK),
        .nrst(NRST),
        .set(events),
        .clear_wr(hit(WR, ADDR, `OFS_STATUS)),
        .mask_wr(hit(WR, ADDR, `OFS_MASK)),
        .wdata(WDATA[`IRQ_FIELD]),
        .status(flags),
        .mask(enables),
        .irq(irq_level)
    );
    // ==========================================
    // Next state: register writes, captures, read data
    always_comb begin
        next_st = st;
        // Timer B load: own writes only when narrow
        if (hit(WR, ADDR, `OFS_B_LOAD) && !WIDE) begin
            next_st.tb_load = WDATA[`HALF_LO];
        end
        // Wide: upper half of the A load lands here
        if (hit(WR, ADDR, `OFS_A_LOAD) && WIDE) begin
            next_st.tb_load = WDATA[`HALF_HI];
        end
        // Timer A match; high half only when wide
        if (hit(WR, ADDR, `OFS_A_MATCH)) begin
            next_st.a_match_lo = WDATA[`HALF_LO];
            if (WIDE) begin
                next_st.a_match_hi = WDATA[`HALF_HI];
            end
        end
        // Timer B match, low field only
        if (hit(WR, ADDR, `OFS_B_MATCH)) begin
            next_st.b_match = WDATA[`HALF_LO];
        end
        // Prescale and prescale match fields
        if (hit(WR, ADDR, `OFS_A_PSC)) begin
            next_st.a_psc = WDATA[`PSC_FIELD];
        end
        if (hit(WR, ADDR, `OFS_B_PSC)) begin
            next_st.b_psc = WDATA[`PSC_FIELD];
        end
        if (hit(WR, ADDR, `OFS_A_PSC_MATCH)) begin
            next_st.a_psc_match = WDATA[`PSC_FIELD];
        end
        if (hit(WR, ADDR, `OFS_B_PSC_MATCH)) begin
            next_st.b_psc_match = WDATA[`PSC_FIELD];
        end
        // Timestamps of the last input edge
        if (EDGE_A && a_view_edge) begin
            next_st.a_stamp = COUNT_A;
        end
        if (EDGE_B && b_view_edge) begin
            next_st.b_stamp = COUNT_B;
        end
        // Edge counting progress and done pulses
        next_st.a_edges = a_step[`HALF_LO];
        next_st.b_edges = b_step[`HALF_LO];
        next_st.edge_done = {b_step[16], a_step[16]};
        // PWM level: high above the match, low below
        next_st.pwm[0] = (A_MODE == MODE_PWM) && !WIDE
                         && (COUNT_A > st.a_match_lo);
        next_st.pwm[1] = (B_MODE == MODE_PWM) && !WIDE
                         && (COUNT_B > st.b_match);
        // Read data: valid in the cycle after the strobe only
        next_st.rdata = `ZERO_WORD;
        if (RD) begin
            unique case (ADDR)
                `OFS_B_LOAD: next_st.rdata = {`ZERO_HALF, st.tb_load};
                `OFS_A_MATCH: begin
                    // High half follows the live width
                    next_st.rdata = {WIDE ? st.a_match_hi : `ZERO_HALF,
                                     st.a_match_lo};
                end
                `OFS_B_MATCH: next_st.rdata = {`ZERO_HALF, st.b_match};
                `OFS_A_PSC: next_st.rdata = {`PAD_PSC, st.a_psc};
                `OFS_B_PSC: next_st.rdata = {`PAD_PSC, st.b_psc};
                `OFS_A_PSC_MATCH: next_st.rdata = {`PAD_PSC, st.a_psc_match};
                `OFS_B_PSC_MATCH: next_st.rdata = {`PAD_PSC, st.b_psc_match};
                `OFS_A_VIEW: begin
                    // Wide: B value on top; narrow: zero
                    next_st.rdata = {WIDE ? b_view : `ZERO_HALF,
                                     a_view_edge ? st.a_stamp : COUNT_A};
                end
                `OFS_B_VIEW: next_st.rdata = {`ZERO_HALF, b_view};
                `OFS_STATUS: next_st.rdata = {`PAD_IRQ, flags};
                `OFS_MASK: next_st.rdata = {`PAD_IRQ, enables};
                // Unmapped addresses read zero
                default: next_st.rdata = `ZERO_WORD;
            endcase
        end
    end
    // ==========================================
    // State register; match high reset follows the width
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            st <= '0;
            st.tb_load <= `RST_HALF;
            st.a_match_hi <= WIDE ? `RST_HALF : `ZERO_HALF;
            st.a_match_lo <= `RST_HALF;
            st.b_match <= `RST_HALF;
            st.a_psc <= `RST_PSC;
            st.b_psc <= `RST_PSC;
            st.a_stamp <= `RST_HALF;
            st.b_stamp <= `RST_HALF;
        end else begin
            st <= next_st;
        end
    end
    // ==========================================
    // Outputs, all from flip-flops
    assign RDATA = st.rdata;
    assign TB_LOAD_VALUE = st.tb_load;
    assign A_PRESCALE = st.a_psc;
    assign B_PRESCALE = st.b_psc;
    assign MATCH_A = match_a_hit;
    assign MATCH_B = match_b_hit;
    assign PWM_A = st.pwm[0];
    assign PWM_B = st.pwm[1];
    assign EDGE_DONE_A = st.edge_done[0];
    assign EDGE_DONE_B = st.edge_done[1];
    assign IRQ = irq_level;
    // ==========================================
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    sequence s_wide_b_write;
        WR && ADDR == `OFS_B_LOAD && WIDE && !(ADDR == `OFS_A_LOAD);
    endsequence
    sequence s_narrow_b_write;
        WR && ADDR == `OFS_B_LOAD && !WIDE;
    endsequence
    load_ignored_a: assert property (s_wide_b_write |=> $stable(st.tb_load))
        else $error("wide write changed timer B load");
    load_written_a: assert property (s_narrow_b_write |=>
        st.tb_load == $past(WDATA[`HALF_LO]))
        else $error("narrow write lost timer B load");
    load_through_a: assert property ((WR && ADDR == `OFS_A_LOAD && WIDE) |=>
        st.tb_load == $past(WDATA[`HALF_HI]))
        else $error("wide A load high missed timer B");
    load_reset_a: assert property ($rose(NRST) |-> st.tb_load == `RST_HALF
        && st.b_stamp == `RST_HALF)
        else $error("reset value wrong");
    match_high_zero_a: assert property ((RD && ADDR == `OFS_A_MATCH && !WIDE) |=>
        RDATA[`HALF_HI] == `ZERO_HALF ##1 RDATA == `ZERO_WORD || $past(RD))
        else $error("narrow match high not zero");
    psc_read_a: assert property ((RD && ADDR == `OFS_A_PSC) |=>
        RDATA == {`PAD_PSC, $past(st.a_psc)})
        else $error("prescale read wrong");
    view_stamp_a: assert property ((RD && ADDR == `OFS_A_VIEW && a_view_edge) |=>
        RDATA[`HALF_LO] == $past(st.a_stamp))
        else $error("edge view not timestamp");
    view_high_a: assert property ((RD && ADDR == `OFS_A_VIEW && WIDE) |=>
        RDATA[`HALF_HI] == $past(b_view))
        else $error("wide view high not timer B");
    edge_done_a: assert property ((a_edge_mode && EDGE_A
        && st.a_edges + 16'h0001 == A_LOAD - st.a_match_lo) |=>
        EDGE_DONE_A && st.a_edges == `ZERO_HALF)
        else $error("edge count end missed");
    // Timer B match read keeps the reserved half at zero
    b_match_read_a: assert property ((RD && ADDR == `OFS_B_MATCH) |=>
        RDATA == {`ZERO_HALF, $past(st.b_match)})
        else $error("timer B match read wrong");
    // Prescale fields come out of reset cleared
    psc_reset_a: assert property ($rose(NRST) |->
        st.a_psc == `RST_PSC && st.b_psc == `RST_PSC)
        else $error("prescale reset value wrong");
    // Prescale match read returns the stored field
    psc_match_read_a: assert property ((RD && ADDR == `OFS_B_PSC_MATCH) |=>
        RDATA == {`PAD_PSC, $past(st.b_psc_match)})
        else $error("prescale match read wrong");
    // Narrow write to A match leaves the high half alone
    match_high_kept_a: assert property ((WR && ADDR == `OFS_A_MATCH && !WIDE) |=>
        $stable(st.a_match_hi))
        else $error("narrow write changed match high");
    // Wide reset leaves ones in the A match high half
    match_high_reset_a: assert property (($rose(NRST) && $past(WIDE)) |->
        st.a_match_hi == `RST_HALF)
        else $error("wide match high reset wrong");
endmodule : timer_match_regs
`default_nettype wire

/* File: test/timer_match_regs_tb.sv */
// Self-checking bench for the timer match, prescale, load and view registers
`include "timer_match_map.svh"
`default_nettype none
module timer_match_regs_tb import timer_match_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Stimulus and observed signals
    logic clock;
    logic nrst;
    logic wr_strobe;
    logic rd_strobe;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wide;
    logic rtc;
    mode_type a_mode;
    mode_type b_mode;
    logic [15:0] a_load;
    logic [15:0] count_a;
    logic [15:0] count_b;
    logic [7:0] psc_count_a;
    logic [7:0] psc_count_b;
    logic edge_a;
    logic edge_b;
    logic [15:0] tb_load_value;
    logic [7:0] a_prescale;
    logic [7:0] b_prescale;
    logic match_a;
    logic match_b;
    logic pwm_a;
    logic pwm_b;
    logic edge_done_a;
    logic edge_done_b;
    logic irq;
    // Bookkeeping: counters, read notes, pulse tallies
    int fails = 0;
    int checks = 0;
    int seed;
    int cycles = 0;
    int hits_a = 0;
    int hits_b = 0;
    int dones_a = 0;
    int dones_b = 0;
    logic [31:0] expq[$];
    logic rd_seen = 1'b0;
    logic [31:0] r0;
    logic [7:0] pm[4];
    timer_match_regs dut (.CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
        .WR(wr_strobe), .RD(rd_strobe), .RDATA(rdata), .WIDE(wide), .RTC(rtc),
        .A_MODE(a_mode), .B_MODE(b_mode), .A_LOAD(a_load), .COUNT_A(count_a),
        .COUNT_B(count_b), .PSC_COUNT_A(psc_count_a), .PSC_COUNT_B(psc_count_b),
        .EDGE_A(edge_a), .EDGE_B(edge_b), .TB_LOAD_VALUE(tb_load_value),
        .A_PRESCALE(a_prescale), .B_PRESCALE(b_prescale), .MATCH_A(match_a),
        .MATCH_B(match_b), .PWM_A(pwm_a), .PWM_B(pwm_b), .EDGE_DONE_A(edge_done_a),
        .EDGE_DONE_B(edge_done_b), .IRQ(irq));
    // ==========================================
    // Clock, 5 ns period
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Compare one value and count it
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Counts, verdict and end of run
    task print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // One-cycle write strobe
    task bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask : bus_write
    // One-cycle read strobe, expected word noted for the monitor
    task bus_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        expq.push_back(exp);
        @(posedge clock);
        rd_strobe <= 1'b0;
    endtask : bus_read
    // ==========================================
    // Monitor: read data stands in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_seen) begin
            check("read data", rdata, expq.pop_front());
        end
        rd_seen <= rd_strobe;
        hits_a <= hits_a + ((match_a === 1'b1) ? 1 : 0);
        hits_b <= hits_b + ((match_b === 1'b1) ? 1 : 0);
        dones_a <= dones_a + ((edge_done_a === 1'b1) ? 1 : 0);
        dones_b <= dones_b + ((edge_done_b === 1'b1) ? 1 : 0);
        cycles <= cycles + 1;
        // Hang guard, far above the roughly 140 cycles needed
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        wide = 1'b0;
        rtc = 1'b0;
        a_mode = MODE_ONE_SHOT;
        b_mode = MODE_ONE_SHOT;
        a_load = 16'h0005;
        count_a = 16'h0100;
        count_b = 16'h0200;
        psc_count_a = 8'h00;
        psc_count_b = 8'h00;
        edge_a = 1'b0;
        edge_b = 1'b0;
        seed = 99322;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        // Reset values in narrow configuration
        bus_read(`OFS_B_LOAD, 32'h0000ffff);
        bus_read(`OFS_A_MATCH, 32'h0000ffff);
        bus_read(`OFS_B_MATCH, 32'h0000ffff);
        for (int i = 0; i < 4; i++) bus_read(`OFS_A_PSC + 8'(4 * i), 32'h0);
        bus_read(8'h60, 32'h0);
        check("load out", {16'h0, tb_load_value}, 32'h0000ffff);
        $display("test reset_values done");
        // Narrow writes: load, match high ignored, prescales, views read-only
        r0 = $random(seed);
        bus_write(`OFS_B_LOAD, r0);
        bus_read(`OFS_B_LOAD, {16'h0, r0[15:0]});
        check("load out", {16'h0, tb_load_value}, {16'h0, r0[15:0]});
        bus_write(`OFS_A_LOAD, 32'h12340000);
        bus_read(`OFS_B_LOAD, {16'h0, r0[15:0]});
        r0 = $random(seed);
        bus_write(`OFS_A_MATCH, r0);
        bus_read(`OFS_A_MATCH, {16'h0, r0[15:0]});
        bus_read(`OFS_B_MATCH, 32'h0000ffff);
        for (int i = 0; i < 4; i++) begin
            r0 = $random(seed);
            pm[i] = r0[7:0];
            bus_write(`OFS_A_PSC + 8'(4 * i), r0);
            bus_read(`OFS_A_PSC + 8'(4 * i), {24'h0, r0[7:0]});
        end
        check("prescale a", {24'h0, a_prescale}, {24'h0, pm[0]});
        check("prescale b", {24'h0, b_prescale}, {24'h0, pm[1]});
        bus_write(`OFS_A_VIEW, 32'hffffffff);
        bus_read(`OFS_A_VIEW, {16'h0, count_a});
        bus_read(`OFS_B_VIEW, {16'h0, count_b});
        $display("test narrow_access done");
        // PWM mode: 24-bit match pulses, duty level, interrupt path
        bus_write(`OFS_A_MATCH, 32'h00000040);
        bus_write(`OFS_B_MATCH, 32'h00000050);
        a_mode <= MODE_PWM;
        b_mode <= MODE_PWM;
        psc_count_a <= pm[2];
        psc_count_b <= pm[3];
        @(posedge clock);
        count_a <= 16'h0040;
        count_b <= 16'h0050;
        repeat (4) @(posedge clock);
        check("match a hits", hits_a, 1);
        check("match b hits", hits_b, 1);
        check("pwm a at match", {31'h0, pwm_a}, 32'h0);
        check("pwm b at match", {31'h0, pwm_b}, 32'h0);
        count_a <= 16'h0041;
        repeat (2) @(posedge clock);
        check("pwm a above", {31'h0, pwm_a}, 32'h1);
        bus_read(`OFS_STATUS, 32'h00000003);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus_write(`OFS_MASK, 32'h00000001);
        repeat (3) @(posedge clock);
        check("irq raised", {31'h0, irq}, 32'h1);
        bus_write(`OFS_STATUS, 32'h00000001);
        repeat (3) @(posedge clock);
        check("irq cleared", {31'h0, irq}, 32'h0);
        bus_read(`OFS_STATUS, 32'h00000002);
        $display("test pwm_match done");
        // Edge count: load 5 minus match 2 gives three edges
        bus_write(`OFS_A_MATCH, 32'h00000002);
        bus_write(`OFS_B_LOAD, 32'h00000005);
        bus_write(`OFS_B_MATCH, 32'h00000002);
        a_mode <= MODE_EDGE_COUNT;
        b_mode <= MODE_EDGE_COUNT;
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            edge_a <= 1'b1;
            edge_b <= 1'b1;
            count_a <= 16'h0120 + 16'(i);
            @(posedge clock);
            edge_a <= 1'b0;
            edge_b <= 1'b0;
            count_a <= 16'h0456;
            repeat (3) @(posedge clock);
            if (i == 1) check("early done", dones_a, 0);
        end
        check("edge done", dones_a, 1);
        check("edge done b", dones_b, 1);
        bus_read(`OFS_A_VIEW, 32'h00000122);
        $display("test edge_count done");
        // Wide configuration after a second reset
        nrst <= 1'b0;
        wide <= 1'b1;
        a_mode <= MODE_PERIODIC;
        b_mode <= MODE_ONE_SHOT;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        bus_read(`OFS_A_MATCH, 32'hffffffff);
        bus_write(`OFS_B_LOAD, 32'h00001111);
        bus_read(`OFS_B_LOAD, 32'h0000ffff);
        bus_write(`OFS_A_LOAD, 32'h22220000);
        bus_read(`OFS_B_LOAD, 32'h00002222);
        check("load out", {16'h0, tb_load_value}, 32'h00002222);
        bus_read(`OFS_A_VIEW, {count_b, count_a});
        rtc <= 1'b1;
        bus_write(`OFS_A_MATCH, 32'h00070009);
        count_b <= 16'h0008;
        count_a <= 16'h0009;
        repeat (4) @(posedge clock);
        check("rtc high differs", hits_a, 1);
        count_b <= 16'h0007;
        repeat (4) @(posedge clock);
        check("rtc match", hits_a, 2);
        wide <= 1'b0;
        bus_read(`OFS_A_MATCH, 32'h00000009);
        bus_read(`OFS_A_VIEW, 32'h00000009);
        repeat (3) @(posedge clock);
        $display("test wide_rtc done");
        print_verdict();
    end
endmodule : timer_match_regs_tb
`default_nettype wire
